//--- rtl/scrp_pkg.sv
// scrp_pkg: constants and types of the serial configuration register port.
// assumes: shared by scrp_top and the test bench; nothing imported.
`default_nettype none
package scrp_pkg;
  // transfer unit and address space
  localparam int unsigned UNIT_W   = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned INPUTS   = 16;
  localparam int unsigned SYNC_N   = 2;
  localparam int unsigned BUF_DEPTH = 2;
  // register offsets
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_BOOST_LO   = 8'h10;
  localparam logic [7:0] ADDR_BOOST_HI   = 8'h11;
  localparam logic [7:0] ADDR_POL_LO     = 8'h12;
  localparam logic [7:0] ADDR_POL_HI     = 8'h13;
  // range the master keeps away from
  localparam logic [7:0] ADDR_RSVD_LO    = 8'hD0;
  localparam logic [7:0] ADDR_RSVD_HI    = 8'hEF;
  // fields and reset values
  localparam int unsigned SOFT_RESET_BIT = 0;
  localparam logic [7:0]  SOFT_RESET_VAL = 8'h01;
  localparam logic [7:0]  RST_BOOST      = 8'hFF;
  localparam logic [7:0]  RST_POL        = 8'h00;
  localparam logic [7:0]  READ_FILL      = 8'h00;
  localparam logic [2:0]  LAST_BIT       = 3'h7;
  // timing: system clock and bench link clock
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned LINK_PERIOD_NS = 125;
  localparam int unsigned LINK_CYCLES    = LINK_PERIOD_NS / CLK_PERIOD_NS;

  // one received unit: address or data
  typedef struct packed {
    logic       is_addr;
    logic [7:0] data;
  } scrp_item_t;

  typedef enum logic [1:0] {
    FR_IDLE,
    FR_WRITE,
    FR_READ
  } scrp_frame_t;
endpackage : scrp_pkg
`default_nettype wire

//--- rtl/scrp_sync.sv
// scrp_sync: two-flop synchroniser for a group of pin levels.
// assumes: inputs asynchronous to ref_clk; only stage two is read outside.
`default_nettype none
module scrp_sync #(
  parameter int unsigned  W       = 3,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] stab_q;
  logic [W-1:0] stab_d;

  always_comb begin
    meta_d = async_in;
    stab_d = meta_q;
  end

  // reset to each pin's idle level, so no false edge follows reset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      stab_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign sync_out = stab_q;
endmodule : scrp_sync
`default_nettype wire

//--- rtl/scrp_buf.sv
// scrp_buf: small valid/ready buffer between receiver and register file.
// assumes: DEPTH is a power of two; both sides on ref_clk.
`default_nettype none
module scrp_buf #(
  parameter int unsigned W     = 9,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [W-1:0]  mem_d [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0]   cnt_q, cnt_d;
  logic          push, pop;

  always_comb begin
    push  = in_valid && in_ready;
    pop   = out_valid && out_ready;
    mem_d = mem_q;
    wp_d  = wp_q;
    rp_d  = rp_q;
    cnt_d = cnt_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = PW'(wp_q + 1'b1);
    end
    if (pop) begin
      rp_d = PW'(rp_q + 1'b1);
    end
    case ({push, pop})
      2'b10:   cnt_d = (PW+1)'(cnt_q + 1'b1);
      2'b01:   cnt_d = (PW+1)'(cnt_q - 1'b1);
      default: cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      mem_q <= mem_d;
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rp_q];
endmodule : scrp_buf
`default_nettype wire

//--- rtl/scrp_top.sv
// scrp_top: serial slave port to the switch's configuration registers.
// assumes: sck, cs_n, sdi come from an outside master and are oversampled.
`default_nettype none
module scrp_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // serial link
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdo_oe,
  // configuration outputs
  output logic [15:0]      input_boost_bit,
  output logic [15:0]      input_invert
);
  logic               s_sck, s_cs_n, s_sdi;
  logic               sck_prev_q, sck_prev_d, cs_prev_q, cs_prev_d;
  logic               sck_rise, sck_fall, cs_fall, cs_rise;
  scrp_pkg::scrp_frame_t frame_q, frame_d;
  logic [2:0]         bit_q, bit_d;
  logic [7:0]         shin_q, shin_d;
  logic               first_q, first_d;
  logic [1:0]         units_q, units_d;
  logic               armed_q, armed_d;
  logic               push_vld_q, push_vld_d;
  scrp_pkg::scrp_item_t push_item_q, push_item_d;
  logic               push_rdy;
  logic [2:0]         rcnt_q, rcnt_d;
  logic [7:0]         shout_q, shout_d;
  logic               sdo_q, sdo_d, oe_q, oe_d;
  logic               rd_inc;
  logic               drn_vld, drn_rdy;
  scrp_pkg::scrp_item_t drn_item;
  logic [7:0]         ptr_q, ptr_d;
  logic [15:0]        boost_q, boost_d, pol_q, pol_d;
  logic [7:0]         rd_cur, rd_next;

  // missing locations and the write-only trigger read as fill
  function automatic logic [7:0] reg_read(input logic [7:0]  a,
                                          input logic [15:0] b,
                                          input logic [15:0] p);
    case (a)
      scrp_pkg::ADDR_BOOST_LO: reg_read = b[7:0];
      scrp_pkg::ADDR_BOOST_HI: reg_read = b[15:8];
      scrp_pkg::ADDR_POL_LO:   reg_read = p[7:0];
      scrp_pkg::ADDR_POL_HI:   reg_read = p[15:8];
      default:                 reg_read = scrp_pkg::READ_FILL;
    endcase
  endfunction : reg_read

  scrp_sync #(
    .W        (3),
    .RST_VAL  (3'h3) // idle: sck low, cs_n and sdi high
  ) u_sync (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .async_in ({sck, cs_n, sdi}),
    .sync_out ({s_sck, s_cs_n, s_sdi})
  );

  // edge detection on synchronised levels
  always_comb begin
    sck_prev_d = s_sck;
    cs_prev_d  = s_cs_n;
    sck_rise   = s_sck && !sck_prev_q;
    sck_fall   = !s_sck && sck_prev_q;
    cs_fall    = !s_cs_n && cs_prev_q;
    cs_rise    = s_cs_n && !cs_prev_q;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_prev_d;
      cs_prev_q  <= cs_prev_d;
    end
  end

  // framing, receive shifter and read shifter
  always_comb begin
    rd_cur      = reg_read(ptr_q, boost_q, pol_q);
    rd_next     = reg_read(8'(ptr_q + 8'h01), boost_q, pol_q);
    frame_d     = frame_q;
    bit_d       = bit_q;
    shin_d      = shin_q;
    first_d     = first_q;
    units_d     = units_q;
    armed_d     = armed_q;
    push_vld_d  = push_vld_q && !push_rdy;
    push_item_d = push_item_q;
    rcnt_d      = rcnt_q;
    shout_d     = shout_q;
    sdo_d       = sdo_q;
    oe_d        = oe_q;
    rd_inc      = 1'b0;
    if (s_cs_n) begin
      frame_d = scrp_pkg::FR_IDLE;
      oe_d    = 1'b0;
      if (cs_rise && frame_q == scrp_pkg::FR_WRITE) begin
        armed_d = (units_q == 2'h1);
      end else if (cs_rise) begin
        armed_d = 1'b0;
      end
    end else if (cs_fall) begin
      bit_d   = '0;
      rcnt_d  = '0;
      first_d = 1'b1;
      units_d = '0;
      if (armed_q) begin
        frame_d = scrp_pkg::FR_READ;
        shout_d = rd_cur;
        sdo_d   = rd_cur[7];
        oe_d    = 1'b1;
      end else begin
        frame_d = scrp_pkg::FR_WRITE;
      end
    end else if (frame_q == scrp_pkg::FR_WRITE && sck_rise) begin
      shin_d = {shin_q[6:0], s_sdi};
      bit_d  = 3'(bit_q + 3'h1);
      if (bit_q == scrp_pkg::LAST_BIT) begin
        push_vld_d  = 1'b1;
        push_item_d = '{is_addr: first_q, data: {shin_q[6:0], s_sdi}};
        first_d     = 1'b0;
        if (units_q != 2'h3) begin
          units_d = 2'(units_q + 2'h1);
        end
      end
    end else if (frame_q == scrp_pkg::FR_READ && sck_fall) begin
      rcnt_d = 3'(rcnt_q + 3'h1);
      if (rcnt_q == scrp_pkg::LAST_BIT) begin
        rd_inc  = 1'b1;
        shout_d = rd_next;
        sdo_d   = rd_next[7];
      end else begin
        shout_d = {shout_q[6:0], 1'b0};
        sdo_d   = shout_q[6];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frame_q     <= scrp_pkg::FR_IDLE;
      bit_q       <= '0;
      shin_q      <= '0;
      first_q     <= 1'b1;
      units_q     <= '0;
      armed_q     <= 1'b0;
      push_vld_q  <= 1'b0;
      push_item_q <= '0;
      rcnt_q      <= '0;
      shout_q     <= '0;
      sdo_q       <= 1'b0;
      oe_q        <= 1'b0;
    end else begin
      frame_q     <= frame_d;
      bit_q       <= bit_d;
      shin_q      <= shin_d;
      first_q     <= first_d;
      units_q     <= units_d;
      armed_q     <= armed_d;
      push_vld_q  <= push_vld_d;
      push_item_q <= push_item_d;
      rcnt_q      <= rcnt_d;
      shout_q     <= shout_d;
      sdo_q       <= sdo_d;
      oe_q        <= oe_d;
    end
  end

  // drain stalls during reads so the pointer has one mover at a time
  assign drn_rdy = (frame_q != scrp_pkg::FR_READ);

  scrp_buf #(
    .W         ($bits(scrp_pkg::scrp_item_t)),
    .DEPTH     (scrp_pkg::BUF_DEPTH)
  ) u_buf (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (push_vld_q),
    .in_ready  (push_rdy),
    .in_data   (push_item_q),
    .out_valid (drn_vld),
    .out_ready (drn_rdy),
    .out_data  (drn_item)
  );

  // pointer and register file
  always_comb begin
    ptr_d   = ptr_q;
    boost_d = boost_q;
    pol_d   = pol_q;
    if (rd_inc) begin
      ptr_d = 8'(ptr_q + 8'h01);
    end
    if (drn_vld && drn_rdy) begin
      if (drn_item.is_addr) begin
        ptr_d = drn_item.data;
      end else begin
        ptr_d = 8'(ptr_q + 8'h01);
        // reserved and missing locations fall to default
        case (ptr_q)
          scrp_pkg::ADDR_SOFT_RESET: begin
            if (drn_item.data[scrp_pkg::SOFT_RESET_BIT]) begin
              boost_d = {2{scrp_pkg::RST_BOOST}};
              pol_d   = {2{scrp_pkg::RST_POL}};
            end
          end
          scrp_pkg::ADDR_BOOST_LO: boost_d[7:0]  = drn_item.data;
          scrp_pkg::ADDR_BOOST_HI: boost_d[15:8] = drn_item.data;
          scrp_pkg::ADDR_POL_LO:   pol_d[7:0]    = drn_item.data;
          scrp_pkg::ADDR_POL_HI:   pol_d[15:8]   = drn_item.data;
          default:                 boost_d = boost_q;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_q   <= '0;
      boost_q <= {2{scrp_pkg::RST_BOOST}};
      pol_q   <= {2{scrp_pkg::RST_POL}};
    end else begin
      ptr_q   <= ptr_d;
      boost_q <= boost_d;
      pol_q   <= pol_d;
    end
  end

  assign sdo             = sdo_q;
  assign sdo_oe          = oe_q;
  assign input_boost_bit = boost_q;
  assign input_invert    = pol_q;

  // checks
  property p_oe_off;
    @(posedge ref_clk) disable iff (!resetn)
    s_cs_n |=> !sdo_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("sdo driven while cs_n high");

  property p_idle_hold;
    @(posedge ref_clk) disable iff (!resetn)
    (frame_q == scrp_pkg::FR_IDLE && !cs_fall) |=>
      (frame_q == scrp_pkg::FR_IDLE);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("frame started without cs_n fall");

  property p_capture;
    @(posedge ref_clk) disable iff (!resetn)
    (frame_q == scrp_pkg::FR_WRITE && sck_rise && !s_cs_n && !cs_fall)
      |=> (shin_q[0] == $past(s_sdi)) && (bit_q == 3'($past(bit_q) + 3'h1));
  endproperty
  a_capture: assert property (p_capture)
    else $error("sdi bit not captured on sck rise");

  property p_sdo_edge;
    @(posedge ref_clk) disable iff (!resetn)
    !$stable(sdo_q) |-> $past(sck_fall || cs_fall);
  endproperty
  a_sdo_edge: assert property (p_sdo_edge)
    else $error("sdo changed outside an sck fall");

  property p_read_start;
    @(posedge ref_clk) disable iff (!resetn)
    (cs_fall && armed_q) |=>
      sdo_oe && (sdo == $past(rd_cur[7])) && (shout_q == $past(rd_cur));
  endproperty
  a_read_start: assert property (p_read_start)
    else $error("read frame did not present pointed byte");

  property p_read_inc;
    @(posedge ref_clk) disable iff (!resetn)
    (frame_q == scrp_pkg::FR_READ && sck_fall && !s_cs_n &&
     rcnt_q == scrp_pkg::LAST_BIT) |=> (ptr_q == 8'($past(ptr_q) + 8'h01));
  endproperty
  a_read_inc: assert property (p_read_inc)
    else $error("pointer not advanced after read byte");

  property p_write_inc;
    @(posedge ref_clk) disable iff (!resetn)
    (drn_vld && drn_rdy && !drn_item.is_addr) |=>
      (ptr_q == 8'($past(ptr_q) + 8'h01));
  endproperty
  a_write_inc: assert property (p_write_inc)
    else $error("pointer not advanced after write byte");

  property p_addr_load;
    @(posedge ref_clk) disable iff (!resetn)
    (drn_vld && drn_rdy && drn_item.is_addr) |=>
      (ptr_q == $past(drn_item.data));
  endproperty
  a_addr_load: assert property (p_addr_load)
    else $error("first unit did not load pointer");

  property p_pol_write;
    @(posedge ref_clk) disable iff (!resetn)
    (drn_vld && drn_rdy && !drn_item.is_addr &&
     ptr_q == scrp_pkg::ADDR_POL_HI) |=>
      (input_invert[15:8] == $past(drn_item.data));
  endproperty
  a_pol_write: assert property (p_pol_write)
    else $error("polarity high byte not stored");

  property p_soft_reset;
    @(posedge ref_clk) disable iff (!resetn)
    (drn_vld && drn_rdy && !drn_item.is_addr &&
     ptr_q == scrp_pkg::ADDR_SOFT_RESET &&
     drn_item.data == scrp_pkg::SOFT_RESET_VAL) |=>
      (boost_q == {2{scrp_pkg::RST_BOOST}}) &&
      (pol_q == {2{scrp_pkg::RST_POL}});
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not restore defaults");

  property p_discard;
    @(posedge ref_clk) disable iff (!resetn)
    (drn_vld && drn_rdy && !drn_item.is_addr &&
     ptr_q != scrp_pkg::ADDR_SOFT_RESET &&
     (ptr_q < scrp_pkg::ADDR_BOOST_LO || ptr_q > scrp_pkg::ADDR_POL_HI)) |=>
      $stable(boost_q) && $stable(pol_q);
  endproperty
  a_discard: assert property (p_discard)
    else $error("write to missing location changed registers");

  c_read_frame: cover property (@(posedge ref_clk) disable iff (!resetn)
    cs_fall && armed_q);
  c_boost_write: cover property (@(posedge ref_clk) disable iff (!resetn)
    drn_vld && !drn_item.is_addr && ptr_q == scrp_pkg::ADDR_BOOST_LO);
  c_buf_full: cover property (@(posedge ref_clk) disable iff (!resetn)
    push_vld_q && !push_rdy);
endmodule : scrp_top
`default_nettype wire

//--- tb/scrp_link_master.sv
// scrp_link_master: behavioural serial master driving the config port.
// assumes: mode 0 link, 125 ns sck period, pulled-up data lines.
`default_nettype none
module scrp_link_master (
  // serial link, master side
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo,
  input  wire logic sdo_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam real HALF_NS = 62.5;

  // sck stands low between frames, sdi floats to its pull-up
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b1;
  end

  task automatic start;
    cs_n = 1'b0;
    #(HALF_NS);
  endtask : start

  // one unit, msb first; sdo is taken at the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sdi = tx[i];
      #(HALF_NS);
      sck   = 1'b1;
      rx[i] = sdo_oe ? sdo : 1'b1; // released line reads its pull-up
      #(HALF_NS);
      sck = 1'b0;
    end
  endtask : xfer

  // cs_n high marks the end; a lone address unit arms a read
  task automatic stop;
    #(HALF_NS);
    cs_n = 1'b1;
    sdi  = 1'b1;
    #(2 * HALF_NS);
  endtask : stop

  // stray clocks with the port deselected, used to probe refusal
  task automatic stray(input logic [7:0] pat);
    for (int i = 7; i >= 0; i--) begin
      sdi = pat[i];
      #(HALF_NS);
      sck = 1'b1;
      #(HALF_NS);
      sck = 1'b0;
    end
    sdi = 1'b1;
  endtask : stray
endmodule : scrp_link_master
`default_nettype wire

//--- tb/test_spi_config_register_port.sv
// test_spi_config_register_port: self-checking bench of scrp_top.
// assumes: scrp_link_master plays the outside master on the link.
`default_nettype none
`define CHECK_VAL(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
  n_errors++; \
  $display("wrong value t=%0t got=%h exp=%h", $time, got, exp); end end
module test_spi_config_register_port;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk;
  logic        resetn;
  logic        sck;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  logic [15:0] input_boost_bit;
  logic [15:0] input_invert;
  logic [7:0]  tx_a [0:7];
  logic [7:0]  rx_a [0:7];
  int          n_errors;
  int          cmp_count;
  int          cyc;

  scrp_top i_scrp_top (
    .ref_clk         (ref_clk),
    .resetn          (resetn),
    .sck             (sck),
    .cs_n            (cs_n),
    .sdi             (sdi),
    .sdo             (sdo),
    .sdo_oe          (sdo_oe),
    .input_boost_bit (input_boost_bit),
    .input_invert    (input_invert)
  );

  scrp_link_master i_scrp_link_master (
    .sck    (sck),
    .cs_n   (cs_n),
    .sdi    (sdi),
    .sdo    (sdo),
    .sdo_oe (sdo_oe)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // a whole run needs well under 10000 cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end

  // output may only move while sck is low
  always @(sdo) begin
    if (sdo_oe === 1'b1 && sck === 1'b1) `CHECK_VAL(sck, 1'b0)
  end

  // addresses stay clear of 0xD0-0xEF throughout
  task automatic wr_burst(input logic [7:0] addr, input int n);
    logic [7:0] rx;
    i_scrp_link_master.start();
    i_scrp_link_master.xfer(addr, rx);
    for (int k = 0; k < n; k++) i_scrp_link_master.xfer(tx_a[k], rx);
    i_scrp_link_master.stop();
  endtask : wr_burst

  task automatic rd_burst(input logic [7:0] addr, input int n);
    wr_burst(addr, 0);
    i_scrp_link_master.start();
    for (int k = 0; k < n; k++) i_scrp_link_master.xfer(8'hFF, rx_a[k]);
    `CHECK_VAL(sdo_oe, 1'b1)
    i_scrp_link_master.stop();
    `CHECK_VAL(sdo_oe, 1'b0)
  endtask : rd_burst

  task automatic t_reset_values;
    `CHECK_VAL(input_boost_bit, {2{scrp_pkg::RST_BOOST}})
    `CHECK_VAL(input_invert, {2{scrp_pkg::RST_POL}})
    `CHECK_VAL(sdo_oe, 1'b0)
  endtask : t_reset_values

  task automatic t_burst;
    tx_a[0] = 8'hA5;
    tx_a[1] = 8'h3C;
    tx_a[2] = 8'h0F;
    tx_a[3] = 8'hF0;
    wr_burst(scrp_pkg::ADDR_BOOST_LO, 4);
    `CHECK_VAL(input_boost_bit, 16'h3CA5)
    `CHECK_VAL(input_invert, 16'hF00F)
  endtask : t_burst

  // runs after t_burst; 0x14 is past the last implemented place
  task automatic t_stream_read;
    tx_a[4] = scrp_pkg::READ_FILL;
    rd_burst(scrp_pkg::ADDR_BOOST_LO, 5);
    for (int k = 0; k < 5; k++) `CHECK_VAL(rx_a[k], tx_a[k])
  endtask : t_stream_read

  // zeros for the two missing places ahead of 0x10
  task automatic t_sparse_write;
    tx_a[0] = 8'h00;
    tx_a[1] = 8'h00;
    tx_a[2] = 8'h5A;
    tx_a[3] = 8'hC3;
    wr_burst(8'h0E, 4);
    `CHECK_VAL(input_boost_bit, 16'hC35A)
    `CHECK_VAL(input_invert, 16'hF00F)
  endtask : t_sparse_write

  // clocks with cs_n high must not shift or misalign anything
  task automatic t_deselect;
    i_scrp_link_master.stray(scrp_pkg::ADDR_POL_LO);
    `CHECK_VAL(sdo_oe, 1'b0)
    i_scrp_link_master.stray(8'h66);
    tx_a[0] = 8'h81;
    wr_burst(scrp_pkg::ADDR_POL_HI, 1);
    `CHECK_VAL(input_invert, 16'h810F)
    `CHECK_VAL(input_boost_bit, 16'hC35A)
  endtask : t_deselect

  task automatic t_soft_reset;
    tx_a[0] = scrp_pkg::SOFT_RESET_VAL;
    wr_burst(scrp_pkg::ADDR_SOFT_RESET, 1);
    `CHECK_VAL(input_boost_bit, 16'hFFFF)
    `CHECK_VAL(input_invert, 16'h0000)
    rd_burst(scrp_pkg::ADDR_SOFT_RESET, 2);
    `CHECK_VAL(rx_a[0], scrp_pkg::READ_FILL)
    `CHECK_VAL(rx_a[1], 8'h00)
  endtask : t_soft_reset

  initial begin
    n_errors  = 0;
    cmp_count = 0;
    cyc       = 0;
    resetn    = 1'b0;
    repeat (20) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (5) @(negedge ref_clk);
    // keeps every link edge off the ref_clk sampling edges
    #1;
    t_reset_values();
    t_burst();
    t_stream_read();
    t_sparse_write();
    t_deselect();
    t_soft_reset();
    final_report();
  end
endmodule : test_spi_config_register_port
`default_nettype wire
